//--- rtl/amp_dev.sv
// Overview of operation
// (RQ1) command mode at reset, drop, escape
// (RQ2) lines start with AT, command follows directly
// (RQ3) exact case match; w r m q z lower
// (RQ4) dial and answer effects end with attempt
// (RQ5) configuration holds until changed or reset
// (RQ6) carriage return ends line; commands may chain
// (RQ7) empty line answers O
// (RQ8) one character at a time; unknown ignored
// (RQ9) only final command's result is returned; r m q bytes are also sent as they run
// (RQ10) host puts answering commands last
// (RQ11) echo command turns echo on or off
// (RQ12) numeric arguments are exactly two hex digits; E and M take one digit, w r m q a raw byte
// (RQ13) silent commands run at once; queries at CR; r m q return their byte at once
// (RQ14) full command set is decoded
// (RQ15) register query reports stored value
// (RQ16) host link rate defaults to 2400 bps
// (RQ17) host waits 1 ms settle before sending
// (RQ18) host escapes by pin or ninth bit
// (RQ19) host waits for result before next line
`timescale 1ns/1ns
module amp_dev
   import amp_pkg::*;
#(
   parameter int         AW  = 8,
   parameter logic [3:0] REV = 4'h0   // revision code, value arbitrary
)(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   amp_link_if.dev          link,
   input  wire logic        LINE_UP,
   output logic             OFF_HOOK,
   output logic             CMD_MODE,
   output logic [7:0]       DIAL_CHAR,
   output logic             DIAL_STB,
   output logic             DIAL_PULSE,
   output logic [7:0]       TX_DATA,
   output logic             TX_STB,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   output logic             RX_READY,
   output logic [1:0]       SPEAKER,
   output logic             V23_REV,
   output logic             WAKE_RING,
   output logic [15:0]      DTE_DIV
);

   initial
   begin
      if (AW < 1 || AW > 8)
         $error("AW must be 1 to 8");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_GOT_A, ST_CMD, ST_DIAL_KIND, ST_DIAL, ST_WAIT_CONN, ST_ARG,
      ST_R_O, ST_S_ADR1, ST_S_ADR2, ST_S_OP, ST_S_VAL1, ST_S_VAL2, ST_B_ADR, ST_B_VAL, ST_DATA
   } amp_st_t;

   typedef enum logic [1:0] {QS_CODE, QS_REG, QS_REV} amp_qsel_t;

   typedef struct packed {
      amp_st_t                    st;
      amp_qsel_t                  qsel;
      logic [7:0]                 cmd;
      logic [7:0]                 adr;
      logic [3:0]                 nib;
      logic [7:0]                 res;
      logic [2:0][7:0]            txq;
      logic [1:0]                 txn;
      logic                       echo;
      logic [1:0]                 spk;
      logic                       v23;
      logic                       wake;
      logic                       hook;
      logic                       pulse;
      logic [7:0]                 dchr;
      logic                       dstb;
      logic [7:0]                 tdat;
      logic                       tstb;
      logic [15:0]                div;
      logic [(1<<AW)-1:0][7:0]    sreg;
   } amp_dev_t;

   amp_dev_t r;
   amp_dev_t n;

   logic       take;
   logic [7:0] c;
   logic [4:0] hv;
   logic       cmd_side;

   // room for echo plus a two-character answer is only guaranteed with an empty queue
   assign cmd_side      = r.st != ST_DATA;
   assign link.tx_ready = CE && r.txn == 2'd0;
   assign link.rx_valid = r.txn != 2'd0;
   assign link.rx_data  = r.txq[0];
   assign RX_READY      = CE && r.st == ST_DATA && r.txn == 2'd0 && !link.esc;
   assign take          = link.tx_valid && link.tx_ready;
   assign c             = link.tx_data[7:0];
   assign hv            = hex_val(c);

   assign OFF_HOOK   = r.hook;
   assign CMD_MODE   = cmd_side;
   assign DIAL_CHAR  = r.dchr;
   assign DIAL_STB   = r.dstb;
   assign DIAL_PULSE = r.pulse;
   assign TX_DATA    = r.tdat;
   assign TX_STB     = r.tstb;
   assign SPEAKER    = r.spk;
   assign V23_REV    = r.v23;
   assign WAKE_RING  = r.wake;
   assign DTE_DIV    = r.div;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n       = r;
      n.dstb  = 1'b0;
      n.tstb  = 1'b0;
      if (link.rx_valid && link.rx_ready)
      begin
         n.txq = {8'h00, r.txq[2:1]};
         n.txn = r.txn - 2'd1;
      end
      if (take && cmd_side && r.echo && !link.tx_data[8])
      begin
         n.txq[n.txn] = c;                                             // [RQ11]
         n.txn        = n.txn + 2'd1;
      end
      // a carriage return inside a command parse closes the line
      if (take && c == CH_CR && r.st inside {ST_CMD, ST_DIAL_KIND, ST_ARG, ST_R_O, ST_S_ADR1,
                                             ST_S_ADR2, ST_S_OP, ST_S_VAL1, ST_S_VAL2, ST_B_ADR, ST_B_VAL})
      begin
         n.st = ST_IDLE;                                               // [RQ6]
         case (r.qsel)                                                 // [RQ9] [RQ13]
            QS_REG:
            begin
               n.txq[n.txn]        = hex_chr(r.sreg[r.adr[AW-1:0]][7:4]);  // [RQ15]
               n.txq[n.txn + 2'd1] = hex_chr(r.sreg[r.adr[AW-1:0]][3:0]);
               n.txn               = n.txn + 2'd2;
            end
            QS_REV:
            begin
               n.txq[n.txn] = CH_0 + {4'h0, REV};
               n.txn        = n.txn + 2'd1;
            end
            default:
            begin
               n.txq[n.txn] = r.res;                                   // [RQ7]
               n.txn        = n.txn + 2'd1;
            end
         endcase
      end
      else if (take)
      begin
         case (r.st)
            ST_IDLE:
               if (c == CH_A)
                  n.st = ST_GOT_A;                                     // [RQ2]
            ST_GOT_A:
            begin
               n.st   = (c == CH_T) ? ST_CMD : ST_IDLE;                // [RQ2] [RQ3]
               n.res  = CH_O;
               n.qsel = QS_CODE;
            end
            ST_CMD:
            begin
               n.cmd  = c;
               n.res  = CH_O;
               n.qsel = QS_CODE;
               case (c)                                                // [RQ14] [RQ3]
                  CH_A:
                  begin
                     n.hook = 1'b1;
                     n.st   = ST_WAIT_CONN;
                  end
                  CH_D:             n.st = ST_DIAL_KIND;
                  CH_E, CH_M:       n.st = ST_ARG;
                  CH_H:             n.hook = 1'b0;
                  CH_I:             n.qsel = QS_REV;
                  CH_O:
                     if (LINE_UP)
                     begin
                        n.st         = ST_DATA;
                        n.txq[n.txn] = CH_LC;
                        n.txn        = n.txn + 2'd1;
                     end
                     else
                        n.res = CH_N;
                  CH_R:             n.st = ST_R_O;
                  CH_S:             n.st = ST_S_ADR1;
                  CH_LW, CH_LR, CH_LM, CH_LQ: n.st = ST_B_ADR;
                  CH_Z:
                  begin
                     n.echo = ECHO_RST;                                // [RQ5]
                     n.spk  = SPK_RST;
                     n.v23  = 1'b0;
                     n.wake = 1'b0;
                     n.hook = 1'b0;
                     n.div  = DTE_DIV_RST;
                     n.sreg = '0;
                  end
                  CH_LZ:            n.wake = 1'b1;
                  default:          n.res = r.res;                     // [RQ8]
               endcase
            end
            ST_DIAL_KIND:
               if (c == CH_T || c == CH_P)
               begin
                  n.pulse = c == CH_P;
                  n.st    = ST_DIAL;
               end
               else
                  n.st = ST_CMD;
            ST_DIAL:
               if (c == CH_CR)
               begin
                  n.hook = 1'b1;
                  n.st   = ST_WAIT_CONN;
               end
               else
               begin
                  n.dchr = c;
                  n.dstb = 1'b1;
               end
            ST_WAIT_CONN:
               // closing CR of an answer line
               if (c == CH_CR && r.cmd == CH_A)
                  n.cmd = CH_CR;
               else
               begin
                  n.hook       = 1'b0;                                 // [RQ4]
                  n.st         = ST_IDLE;
                  n.txq[n.txn] = CH_N;
                  n.txn        = n.txn + 2'd1;
               end
            ST_ARG:
            begin
               n.st = ST_CMD;
               if (r.cmd == CH_E && (c == CH_0 || c == CH_0 + 8'h01))
                  n.echo = c[0];                                       // [RQ11]
               else if (r.cmd == CH_M && c >= CH_0 && c <= CH_0 + 8'h03)
                  n.spk = c[1:0];
            end
            ST_R_O:
            begin
               n.st = ST_CMD;
               if (c == CH_O)
               begin
                  n.v23 = !r.v23;
                  if (LINE_UP)
                  begin
                     n.st         = ST_DATA;
                     n.txq[n.txn] = CH_LC;
                     n.txn        = n.txn + 2'd1;
                  end
                  else
                     n.res = CH_N;
               end
            end
            ST_S_ADR1, ST_S_ADR2, ST_S_VAL1, ST_S_VAL2:
               if (!hv[4])
                  n.st = ST_CMD;                                       // [RQ12]
               else if (r.st == ST_S_ADR1 || r.st == ST_S_VAL1)
               begin
                  n.nib = hv[3:0];
                  n.st  = (r.st == ST_S_ADR1) ? ST_S_ADR2 : ST_S_VAL2;
               end
               else if (r.st == ST_S_ADR2)
               begin
                  n.adr = {r.nib, hv[3:0]};
                  n.st  = ST_S_OP;
               end
               else
               begin
                  n.sreg[r.adr[AW-1:0]] = {r.nib, hv[3:0]};            // [RQ13]
                  n.st                  = ST_CMD;
               end
            ST_S_OP:
            begin
               n.st = (c == CH_EQ) ? ST_S_VAL1 : ST_CMD;
               if (c == CH_QM)
                  n.qsel = QS_REG;
            end
            ST_B_ADR:
            begin
               n.adr = c;
               n.st  = ST_CMD;
               if (r.cmd == CH_LW)
                  n.st = ST_B_VAL;
               else
               begin
                  n.txq[n.txn] = r.sreg[c[AW-1:0]];
                  n.txn        = n.txn + 2'd1;
               end
            end
            ST_B_VAL:
            begin
               n.sreg[r.adr[AW-1:0]] = c;
               n.st                  = ST_CMD;
            end
            ST_DATA:
               if (!link.tx_data[8])
               begin
                  n.tdat = c;
                  n.tstb = 1'b1;
               end
            default: n.st = ST_IDLE;
         endcase
      end
      // leaving data mode, line data and connect; only acts with an empty queue so the code fits
      if (r.st == ST_DATA && r.txn == 2'd0)
      begin
         if (link.esc || (take && link.tx_data[8]))
         begin
            n.st         = ST_IDLE;                                    // [RQ1] [RQ18]
            n.txq[0]     = CH_O;
            n.txn        = 2'd1;
         end
         else if (!LINE_UP)
         begin
            n.st         = ST_IDLE;                                    // [RQ1] [RQ4]
            n.hook       = 1'b0;
            n.txq[0]     = CH_N;
            n.txn        = 2'd1;
         end
         else if (RX_VALID)
         begin
            n.txq[0]     = RX_DATA;
            n.txn        = 2'd1;
         end
      end
      else if (r.st == ST_WAIT_CONN && LINE_UP && !take && r.txn == 2'd0)
      begin
         n.st     = ST_DATA;
         n.txq[0] = CH_LC;
         n.txn    = 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         r      <= '0;
         r.st   <= ST_IDLE;                                            // [RQ1]
         r.qsel <= QS_CODE;
         r.res  <= CH_O;
         r.echo <= ECHO_RST;
         r.spk  <= SPK_RST;
         r.div  <= DTE_DIV_RST;                                        // [RQ16]
         r.sreg <= {(1<<AW){SREG_RST}};
      end
      else if (CE)
         r <= n;
   end

endmodule

//--- rtl/amp_pkg.sv
package amp_pkg;

   // ----------------------------------------------------------------
   // characters seen on the command link
   // ----------------------------------------------------------------
   localparam logic [7:0] CH_CR    = 8'h0d;
   localparam logic [7:0] CH_A     = 8'h41;
   localparam logic [7:0] CH_T     = 8'h54;
   localparam logic [7:0] CH_D     = 8'h44;
   localparam logic [7:0] CH_P     = 8'h50;
   localparam logic [7:0] CH_E     = 8'h45;
   localparam logic [7:0] CH_H     = 8'h48;
   localparam logic [7:0] CH_I     = 8'h49;
   localparam logic [7:0] CH_M     = 8'h4d;
   localparam logic [7:0] CH_O     = 8'h4f;
   localparam logic [7:0] CH_R     = 8'h52;
   localparam logic [7:0] CH_S     = 8'h53;
   localparam logic [7:0] CH_Z     = 8'h5a;
   localparam logic [7:0] CH_N     = 8'h4e;
   localparam logic [7:0] CH_LW    = 8'h77;
   localparam logic [7:0] CH_LR    = 8'h72;
   localparam logic [7:0] CH_LM    = 8'h6d;
   localparam logic [7:0] CH_LQ    = 8'h71;
   localparam logic [7:0] CH_LZ    = 8'h7a;
   localparam logic [7:0] CH_LC    = 8'h63;
   localparam logic [7:0] CH_EQ    = 8'h3d;
   localparam logic [7:0] CH_QM    = 8'h3f;
   localparam logic [7:0] CH_0     = 8'h30;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic       ECHO_RST    = 1'b0;
   localparam logic [1:0] SPK_RST     = 2'h1;
   localparam logic [7:0] SREG_RST    = 8'h00;
   localparam int         CLK_HZ      = 100_000_000;
   localparam int         DTE_BPS_DEF = 2400;
   localparam logic [15:0] DTE_DIV_RST = 16'(CLK_HZ / DTE_BPS_DEF);
   localparam int         SETTLE_US   = 1000;
   localparam int         SETTLE_CYC  = SETTLE_US * (CLK_HZ / 1_000_000);

   // ----------------------------------------------------------------
   // hex helpers
   // ----------------------------------------------------------------
   // bit 4 flags a valid hex digit; upper case only
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39)
         return {1'b1, 4'(c - 8'h30)};
      else if (c >= 8'h41 && c <= 8'h46)
         return {1'b1, 4'(c - 8'h37)};
      else
         return 5'h00;
   endfunction

   function automatic logic [7:0] hex_chr(input logic [3:0] n);
      if (n < 4'ha)
         return 8'h30 + {4'h0, n};
      else
         return 8'h37 + {4'h0, n};
   endfunction

endpackage

//--- rtl/amp_link_if.sv
`timescale 1ns/1ns
interface amp_link_if;
   logic       tx_valid;
   logic [8:0] tx_data;
   logic       tx_ready;
   logic       rx_valid;
   logic [7:0] rx_data;
   logic       rx_ready;
   logic       esc;

   modport dev  (input tx_valid, tx_data, rx_ready, esc, output tx_ready, rx_valid, rx_data);
   modport host (output tx_valid, tx_data, rx_ready, esc, input tx_ready, rx_valid, rx_data);
endinterface

//--- rtl/amp_host.sv
`timescale 1ns/1ns
module amp_host
   import amp_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC
)(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   amp_link_if.host         link,
   input  wire logic [8:0]  CMD_DATA,
   input  wire logic        CMD_VALID,
   output logic             CMD_READY,
   input  wire logic        ESC_REQ,
   output logic [7:0]       RSP_DATA,
   output logic             RSP_VALID,
   output logic             REFUSED,
   output logic             SETTLED,
   output logic             BUSY
);

   initial
   begin
      if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 2**24 - 1)
         $error("SETTLE_CYCLES out of range");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [23:0] cnt;
      logic        settled;
      logic [1:0]  pos;
      logic        wait_rsp;
      logic        prev_q;
      logic        online;
      logic [7:0]  rsp;
      logic        rsp_v;
      logic        refused;
   } amp_host_t;

   amp_host_t r;
   amp_host_t n;

   logic       bad;
   logic       go;
   logic [7:0] ch;

   assign ch = CMD_DATA[7:0];
   // a refused character is consumed here and never reaches the link
   assign bad = !r.online && !CMD_DATA[8] &&
                ((r.pos == 2'd0 && ch != CH_A) ||                      // [RQ2] [RQ3]
                 (r.pos == 2'd1 && ch != CH_T) ||
                 (r.prev_q && ch != CH_CR));                           // [RQ10]
   assign go  = CE && r.settled && !r.wait_rsp;                        // [RQ17] [RQ19]

   assign link.tx_valid = go && CMD_VALID && !bad;
   assign link.tx_data  = CMD_DATA;
   assign link.rx_ready = CE;
   assign link.esc      = ESC_REQ && r.settled;                        // [RQ18]
   assign CMD_READY     = go && (bad || link.tx_ready);
   assign RSP_DATA      = r.rsp;
   assign RSP_VALID     = r.rsp_v;
   assign REFUSED       = r.refused;
   assign SETTLED       = r.settled;
   assign BUSY          = r.wait_rsp;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n         = r;
      n.rsp_v   = 1'b0;
      n.refused = 1'b0;
      if (!r.settled)
      begin
         n.cnt     = r.cnt + 24'h000001;
         n.settled = r.cnt == 24'(SETTLE_CYCLES - 1);
      end
      if (ESC_REQ && r.settled)
         n.online = 1'b0;
      if (CMD_VALID && CMD_READY)
      begin
         if (bad)
            n.refused = 1'b1;
         else if (CMD_DATA[8])
            n.online = 1'b0;
         else if (!r.online)
         begin
            n.prev_q = ch == CH_QM;
            if (ch == CH_CR)
            begin
               n.pos      = 2'd0;                                      // [RQ6]
               n.wait_rsp = 1'b1;                                      // [RQ19]
            end
            else if (r.pos != 2'd2)
               n.pos = r.pos + 2'd1;
         end
      end
      if (link.rx_valid && link.rx_ready)
      begin
         n.rsp   = link.rx_data;
         n.rsp_v = 1'b1;
         // the echoed carriage return does not end the wait
         if (r.wait_rsp && link.rx_data != CH_CR)
            n.wait_rsp = 1'b0;
         if (!r.online && link.rx_data == CH_LC)
         begin
            n.online   = 1'b1;
            n.wait_rsp = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         r <= '0;
      else if (CE)
         r <= n;
   end

endmodule

//--- test/amp_link_monitor.sv
`timescale 1ns/1ns
module amp_link_monitor
   import amp_pkg::*;
#(
   parameter int SETTLE_CYCLES = 20
)(
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       tx_valid,
   input wire logic [8:0] tx_data,
   input wire logic       tx_ready,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_ready,
   input wire logic       esc
);
   // ----------------------------------------------------------------
   // helper state: last two characters taken, echo setting
   // ----------------------------------------------------------------
   logic       acc;
   logic [7:0] d;
   logic [7:0] p0_r;
   logic [7:0] p1_r;
   logic       echo_r;
   int         cnt_r;
   assign acc = tx_valid && tx_ready;
   assign d   = tx_data[7:0];
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         p0_r   <= 8'h00;
         p1_r   <= 8'h00;
         echo_r <= 1'b0;
         cnt_r  <= 0;
      end
      else
      begin
         if (cnt_r < SETTLE_CYCLES)
            cnt_r <= cnt_r + 1;
         if (acc)
         begin
            p0_r <= d;
            p1_r <= p0_r;
            // echo flag is only exact in command mode; dial strings never hold E1
            if (p0_r == CH_E && d == 8'h31)
               echo_r <= 1'b1;
            else if ((p0_r == CH_E && d == CH_0) || d == CH_Z)
               echo_r <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // link properties
   // ----------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_quiet_settle: assert property (cnt_r < SETTLE_CYCLES |-> !tx_valid && !esc)
      else $error("link used before settle");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("offered character changed before taken");
   a_queue_blocks: assert property (rx_valid |-> !tx_ready)
      else $error("character taken while answer pending");
   a_empty_line: assert property (acc && d == CH_CR && p0_r == CH_T && p1_r == CH_A
      |-> ##[1:20] (rx_valid && rx_data == CH_O))
      else $error("empty line not answered");
   a_echo_char: assert property (acc && echo_r && !(p0_r == CH_E && d == CH_0) && d != CH_Z
      |=> rx_valid && rx_data == $past(d))
      else $error("character not echoed");
   a_silent_cmd: assert property (acc && !echo_r && !tx_data[8] && d != CH_CR && d != CH_O |=> !rx_valid)
      else $error("answer before end of line");
   a_ninth_escape: assert property (acc && tx_data[8] |-> ##[1:3] (rx_valid && rx_data == CH_O))
      else $error("ninth bit escape not answered");
   a_wait_result: assert property (acc && d == CH_CR |=> !tx_valid [*2])
      else $error("next line sent before result");
endmodule

//--- test/modem_at_command_parser_tb.sv
`timescale 1ns/1ns
module modem_at_command_parser_tb
   import amp_pkg::*;
;
   localparam logic [15:0] DIV_EXP = 16'(100_000_000 / 2400);
   logic       clk, rst, cmd_v, cmd_rdy, rsp_v, refused, settled, busy, line_up, rx_v, rx_rdy, esc_req, v23, wake;
   logic       off_hook, cmd_mode, dial_stb, dial_pulse, ltx_stb;
   logic [8:0] cmd_d;
   logic [7:0] rsp_d, dial_c, ltx_d, rx_d, dial_last, line_tx;
   logic [1:0] spk;
   logic [15:0] dte_div;
   logic [7:0] rq[$];
   int         bad_count, checks, nref;
   amp_link_if i_amp_link_if ();
   amp_dev i_amp_dev (.CLK(clk), .RST(rst), .CE(1'b1), .link(i_amp_link_if), .LINE_UP(line_up),
      .OFF_HOOK(off_hook), .CMD_MODE(cmd_mode), .DIAL_CHAR(dial_c), .DIAL_STB(dial_stb),
      .DIAL_PULSE(dial_pulse), .TX_DATA(ltx_d), .TX_STB(ltx_stb), .RX_DATA(rx_d), .RX_VALID(rx_v),
      .RX_READY(rx_rdy), .SPEAKER(spk), .V23_REV(v23), .WAKE_RING(wake), .DTE_DIV(dte_div));
   amp_host #(.SETTLE_CYCLES(20)) i_amp_host (.CLK(clk), .RST(rst), .CE(1'b1), .link(i_amp_link_if),
      .CMD_DATA(cmd_d), .CMD_VALID(cmd_v), .CMD_READY(cmd_rdy), .ESC_REQ(esc_req), .RSP_DATA(rsp_d),
      .RSP_VALID(rsp_v), .REFUSED(refused), .SETTLED(settled), .BUSY(busy));
   amp_link_monitor #(.SETTLE_CYCLES(20)) i_amp_link_monitor (.CLK(clk), .RST(rst),
      .tx_valid(i_amp_link_if.tx_valid), .tx_data(i_amp_link_if.tx_data), .tx_ready(i_amp_link_if.tx_ready),
      .rx_valid(i_amp_link_if.rx_valid), .rx_data(i_amp_link_if.rx_data), .rx_ready(i_amp_link_if.rx_ready),
      .esc(i_amp_link_if.esc));
   // ----------------------------------------------------------------
   // clock and observers
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (rsp_v === 1'b1) rq.push_back(rsp_d);
      if (refused === 1'b1) nref++;
      if (dial_stb === 1'b1) dial_last = dial_c;
      if (ltx_stb === 1'b1) line_tx = ltx_d;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until the edge that samples ready, then released a cycle apart
   task automatic send(input logic [8:0] c);
      cmd_d = c;
      cmd_v = 1'b1;
      for (int n = 0; n < 500 && cmd_rdy !== 1'b1; n++) tick(1);
      chk(8'(cmd_rdy), 8'h01);
      tick(1);
      cmd_v = 1'b0;
      cmd_d = ~c;
      tick(1);
   endtask
   task automatic send_str(input string s);
      rq.delete();
      foreach (s[i]) send({1'b0, s[i]});
   endtask
   task automatic wait_rsp();
      for (int n = 0; n < 500 && rq.size() == 0; n++) tick(1);
      chk(8'(rq.size() != 0), 8'h01);
      tick(6);
   endtask
   task automatic line(input string s);
      send_str(s);
      send({1'b0, CH_CR});
      wait_rsp();
   endtask
   task end_of_test();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst = 1'b1; cmd_v = 1'b0; cmd_d = 9'h000; line_up = 1'b0; rx_v = 1'b0; rx_d = 8'h00;
      bad_count = 0; checks = 0; nref = 0;
      esc_req = 1'b0;
      tick(2);
      rst = 1'b0;
      chk(dte_div[15:8], DIV_EXP[15:8]);
      chk(dte_div[7:0], DIV_EXP[7:0]);
      chk(8'(cmd_mode), 8'h01);
      for (int n = 0; n < 100 && settled !== 1'b1; n++) tick(1);
      send(9'h061);
      tick(3);
      chk(8'(nref), 8'h01);
      line("AT");
      chk(8'(rq.size()), 8'h01);
      chk(rq[0], CH_O);
      line("ATE1");
      chk(rq[0], CH_CR);
      chk(rq[$], CH_O);
      line("ATE0");
      line("AT");
      chk(8'(rq.size()), 8'h01);
      line("ATS05=3C");
      line("ATS05?");
      chk(rq[0], 8'h33);
      chk(rq[1], 8'h43);
      send_str("ATM3");
      tick(2);
      chk(8'(spk), 8'h03);
      line("#V");
      chk(8'(rq.size()), 8'h01);
      chk(rq[0], CH_O);
      line("ATZ");
      chk(8'(spk), 8'h01);
      line("ATS05?");
      chk(rq[0], CH_0);
      chk(rq[1], CH_0);
      line("ATz");
      chk(8'(wake), 8'h01);
      line("ATRO");
      chk(8'(v23), 8'h01);
      send_str("ATDT5");
      send({1'b0, CH_CR});
      chk(dial_last, 8'h35);
      chk(8'(dial_pulse), 8'h00);
      tick(2);
      chk(8'(off_hook), 8'h01);
      line_up = 1'b1;
      wait_rsp();
      chk(rq[0], 8'h63);
      chk(8'(cmd_mode), 8'h00);
      rq.delete();
      send(9'h078);
      tick(2);
      chk(line_tx, 8'h78);
      rx_d = 8'h55;
      rx_v = 1'b1;
      for (int n = 0; n < 50 && rx_rdy !== 1'b1; n++) tick(1);
      tick(1);
      rx_v = 1'b0;
      rx_d = 8'haa;
      wait_rsp();
      chk(rq[0], 8'h55);
      rq.delete();
      send(9'h100);
      wait_rsp();
      chk(rq[0], CH_O);
      chk(8'(cmd_mode), 8'h01);
      line("ATH");
      line_up = 1'b0;
      chk(8'(off_hook), 8'h00);
      send_str("ATDP");
      send({1'b0, CH_CR});
      chk(8'(dial_pulse), 8'h01);
      line_up = 1'b1;
      wait_rsp();
      chk(rq[0], 8'h63);
      rq.delete();
      esc_req = 1'b1;
      wait_rsp();
      esc_req = 1'b0;
      chk(rq[0], CH_O);
      send_str("ATO");
      wait_rsp();
      chk(rq[0], 8'h63);
      rq.delete();
      line_up = 1'b0;
      wait_rsp();
      chk(rq[0], CH_N);
      chk(8'(off_hook), 8'h00);
      chk(8'(cmd_mode), 8'h01);
      end_of_test();
   end
   // run needs well under a thousand cycles; ten thousand marks a hang
   initial
   begin
      #100000;
      bad_count++;
      end_of_test();
   end
endmodule
